// ### design/aap_pkg.sv
package aap_pkg;

   //==========================================================
   // Register map, byte addresses.
   localparam logic [7:0] ADDR_PRE   = 8'h00;
   localparam logic [7:0] ADDR_GAIN  = 8'h04;
   localparam logic [7:0] ADDR_LIM   = 8'h08;
   localparam logic [7:0] ADDR_POST  = 8'h0c;
   localparam logic [7:0] ADDR_CLAMP = 8'h10;
   localparam logic [7:0] ADDR_MISC  = 8'h14;
   localparam logic [7:0] ADDR_COEF  = 8'h18;
   localparam logic [7:0] ADDR_STAT  = 8'h1c;

   //==========================================================
   // Writable bits of each word; all others read as zero.
   localparam logic [31:0] MASK_PRE   = 32'h00fff000;
   localparam logic [31:0] MASK_GAIN  = 32'h02001fff;
   localparam logic [31:0] MASK_LIM   = 32'h03ffffff;
   localparam logic [31:0] MASK_POST  = 32'h00fff000;
   localparam logic [31:0] MASK_CLAMP = 32'h00ffffff;
   localparam logic [31:0] MASK_MISC  = 32'h00000307;
   localparam logic [31:0] MASK_COEF  = 32'h0000ffff;

   //==========================================================
   // Field positions.
   localparam int PRE_LSB    = 12;
   localparam int NARROW_BIT = 25;
   localparam int HOLD_BIT   = 25;
   localparam int WRAP_BIT   = 24;
   localparam int MAX_LSB    = 12;
   localparam int MIN_LSB    = 0;
   localparam int POST_LSB   = 12;
   localparam int HIGH_LSB   = 12;
   localparam int LOW_LSB    = 0;
   localparam int SEL_LSB    = 0;
   localparam int POL_BIT    = 8;
   localparam int DMASK_BIT  = 9;
   localparam int TCOEF_LSB  = 8;
   localparam int FCOEF_LSB  = 0;

   //==========================================================
   // Reset values and arithmetic constants.
   localparam logic [31:0] RST_ZERO   = 32'h00000000;
   localparam logic [31:0] RST_COEF   = 32'h00000000;
   localparam logic [13:0] GAIN_ONE   = 14'h0100;
   localparam logic [12:0] FULL_TURN  = 13'h1000;
   localparam int          DRIFT_SHR  = 6;
   localparam logic [1:0]  RESP_OKAY  = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   //==========================================================
   // Configuration as seen by the angle path.
   typedef struct packed {
      logic [11:0]       pre_shift;
      logic              narrow_en;
      logic [12:0]       gain;
      logic              limit_hold_en;
      logic              wrap_enable;
      logic [11:0]       max_in;
      logic [11:0]       min_in;
      logic [11:0]       post_scale_shift;
      logic [11:0]       high_lim;
      logic [11:0]       low_lim;
      logic [2:0]        sample_average_select;
      logic              polarity;
      logic              diag_mask;
      logic signed [7:0] temp_coef;
      logic signed [7:0] field_coef;
   } aap_cfg_t;

endpackage

// ### design/aap_avg.sv
`timescale 1ns/10ps
`default_nettype none
// Sums a power-of-two group of samples and emits the mean once.
module aap_avg #(
   parameter int DATA_W = 12,
   parameter int SEL_W  = 3
) (
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Group size select.
   input  wire logic [SEL_W-1:0]  sel,
   // Sample stream in.
   input  wire logic              in_valid,
   input  wire logic [DATA_W-1:0] in_data,
   // Mean out.
   output logic                   out_valid,
   output logic [DATA_W-1:0]      out_data
);
   localparam int CNT_W = (1 << SEL_W) - 1;
   localparam int ACC_W = DATA_W + CNT_W;

   // Refused at elaboration: the counter width grows as 2**SEL_W.
   if (DATA_W < 1 || SEL_W < 1 || SEL_W > 4) begin : g_bad_width
      $error("aap_avg: unsupported width");
   end

   logic [ACC_W-1:0] acc;        // Running sum of the group.
   logic [CNT_W-1:0] cnt;        // Samples already in the sum.

   //==========================================================
   // Group bookkeeping.
   wire [CNT_W:0]   group_len = (CNT_W+1)'(1) << sel;
   wire             last      = {1'b0, cnt} >= (group_len - 1'b1);
   wire [ACC_W-1:0] sum_next  = acc + ACC_W'(in_data);
   wire [ACC_W-1:0] mean      = sum_next >> sel;

   // The group restarts after each mean, so a changed select takes
   // full effect from the next group; a mid-group shrink ends the group
   // in flight at its next sample once the count has reached the new size,
   // instead of letting the count run on.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc       <= '0;
         cnt       <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         out_valid <= 1'b0;
         if (in_valid && last) begin
            acc       <= '0;
            cnt       <= '0;
            out_valid <= 1'b1;
            out_data  <= mean[DATA_W-1:0];
         end else if (in_valid) begin
            acc <= sum_next;
            cnt <= cnt + 1'b1;
         end
      end
   end

endmodule // aap_avg
`default_nettype wire

// ### design/aap_top.sv
`timescale 1ns/10ps
`default_nettype none
// Angle post-processing path with an AXI4-Lite register slave.
module aap_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write channels.
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read channels.
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Raw angle front end, same clock.
   input  wire logic              raw_valid,
   input  wire logic [11:0]       raw_angle,
   input  wire logic signed [7:0] die_temp,
   input  wire logic signed [7:0] field_level,
   // Output driver.
   output logic                   out_valid,
   output logic [11:0]            out_angle,
   output logic                   out_tristate
);
   // Refused at elaboration: the hit decode needs bits above bit 4.
   if (ADDR_W < 6) begin : g_bad_addr
      $error("aap_top: address too narrow for the map");
   end

   //==========================================================
   // Register storage, one word per index.
   logic [31:0] regs [0:6];
   aap_pkg::aap_cfg_t cfg;

   wire [2:0] widx   = awaddr[4:2];
   wire [2:0] ridx   = araddr[4:2];
   wire       whit   = awaddr[ADDR_W-1:5] == '0 && awaddr[4:2] != 3'h7;
   wire       rhit   = araddr[ADDR_W-1:5] == '0;
   wire       wtake  = awvalid && wvalid && !awready && !bvalid;
   wire       rtake  = arvalid && !arready && !rvalid;
   wire [31:0] bmask = {{8{wstrb[3]}}, {8{wstrb[2]}},
                        {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire [31:0] stat  = {19'h0, out_tristate, out_angle};

   // Writable-bit masks by index.
   logic [31:0] wmask [0:6];
   assign wmask[0] = aap_pkg::MASK_PRE;
   assign wmask[1] = aap_pkg::MASK_GAIN;
   assign wmask[2] = aap_pkg::MASK_LIM;
   assign wmask[3] = aap_pkg::MASK_POST;
   assign wmask[4] = aap_pkg::MASK_CLAMP;
   assign wmask[5] = aap_pkg::MASK_MISC;
   assign wmask[6] = aap_pkg::MASK_COEF;

   wire [31:0] rword = (ridx == 3'h7) ? stat : regs[ridx];

   // Register words unpacked into the path configuration.
   assign cfg.pre_shift  = regs[0][aap_pkg::PRE_LSB +: 12];
   assign cfg.narrow_en  = regs[1][aap_pkg::NARROW_BIT];
   assign cfg.gain       = regs[1][12:0];
   assign cfg.limit_hold_en = regs[2][aap_pkg::HOLD_BIT];
   assign cfg.wrap_enable   = regs[2][aap_pkg::WRAP_BIT];
   assign cfg.max_in     = regs[2][aap_pkg::MAX_LSB +: 12];
   assign cfg.min_in     = regs[2][aap_pkg::MIN_LSB +: 12];
   assign cfg.post_scale_shift = regs[3][aap_pkg::POST_LSB +: 12];
   assign cfg.high_lim   = regs[4][aap_pkg::HIGH_LSB +: 12];
   assign cfg.low_lim    = regs[4][aap_pkg::LOW_LSB +: 12];
   assign cfg.sample_average_select = regs[5][aap_pkg::SEL_LSB +: 3];
   assign cfg.polarity   = regs[5][aap_pkg::POL_BIT];
   assign cfg.diag_mask  = regs[5][aap_pkg::DMASK_BIT];
   assign cfg.temp_coef  = regs[6][aap_pkg::TCOEF_LSB +: 8];
   assign cfg.field_coef = regs[6][aap_pkg::FCOEF_LSB +: 8];

   //==========================================================
   // Write path: address and data are taken together, one cycle of
   // ready, then the response waits for bready.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= aap_pkg::RESP_OKAY;
         for (int i = 0; i < 6; i++) begin
            regs[i] <= aap_pkg::RST_ZERO;
         end
         regs[6] <= aap_pkg::RST_COEF;
      end else begin
         awready <= wtake;
         wready  <= wtake;
         if (wtake) begin
            bvalid <= 1'b1;
            bresp  <= whit ? aap_pkg::RESP_OKAY : aap_pkg::RESP_SLVERR;
            if (whit) begin
               regs[widx] <= ((regs[widx] & ~bmask) | (wdata & bmask))
                             & wmask[widx];
            end
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   //==========================================================
   // Read path: data is loaded with arready and held until rready.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= aap_pkg::RESP_OKAY;
      end else begin
         arready <= rtake;
         if (rtake) begin
            rvalid <= 1'b1;
            rdata  <= rhit ? rword : 32'h00000000;
            rresp  <= rhit ? aap_pkg::RESP_OKAY : aap_pkg::RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   //==========================================================
   // Drift compensation: a linear correction in temperature and
   // field, scaled down so the coefficients stay fine-grained.
   wire signed [15:0] t_term = die_temp * cfg.temp_coef;
   wire signed [15:0] f_term = field_level * cfg.field_coef;
   wire signed [16:0] drift  = (17'(t_term) + 17'(f_term))
                               >>> aap_pkg::DRIFT_SHR;
   wire [11:0] comp_ang = raw_angle - drift[11:0];

   //==========================================================
   // Power-of-two averaging.
   logic        avg_valid;
   logic [11:0] avg_ang;

   aap_avg #(
      .DATA_W (12),
      .SEL_W  (3)
   ) u_avg (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sel       (cfg.sample_average_select),
      .in_valid  (raw_valid),
      .in_data   (comp_ang),
      .out_valid (avg_valid),
      .out_data  (avg_ang)
   );

   //==========================================================
   // Offset, limit check, gain, post shift.
   wire [11:0] pre_ang   = avg_ang - cfg.pre_shift;
   wire        off_range = pre_ang < cfg.min_in ||
                           pre_ang > cfg.max_in;
   wire        range_fault = cfg.narrow_en && off_range
                             && !cfg.diag_mask;
   wire [13:0] mult   = aap_pkg::GAIN_ONE + {1'b0, cfg.gain};
   wire [25:0] prod   = pre_ang * mult;
   // Gain of up to 33x lets a 1/32 turn span cover the full scale.
   wire [17:0] gained = cfg.narrow_en ? prod[25:8] : {6'h0, pre_ang};
   wire [18:0] post_sum = {1'b0, gained}
                          + {7'h0, cfg.post_scale_shift};
   wire [11:0] wrapped  = post_sum[11:0];

   // Window arithmetic for wrapping between the output limits.
   wire [12:0] span    = {1'b0, cfg.high_lim} - {1'b0, cfg.low_lim}
                         + 13'h0001;
   wire        win_ok  = cfg.high_lim >= cfg.low_lim;
   wire [11:0] rel     = wrapped - cfg.low_lim;
   wire [12:0] rel_mod = {1'b0, rel} % (win_ok ? span : 13'h0001);
   wire [11:0] rolled  = cfg.low_lim + rel_mod[11:0];
   wire        sat_hi  = post_sum > {7'h0, cfg.high_lim};
   wire        sat_lo  = post_sum < {7'h0, cfg.low_lim};
   wire        w_hi    = wrapped > cfg.high_lim;
   wire        w_lo    = wrapped < cfg.low_lim;

   //==========================================================
   // Output treatment chosen by hold and wrap enables.
   logic [11:0] shaped;
   always_comb begin
      unique case ({cfg.limit_hold_en, cfg.wrap_enable})
         2'b00: begin
            shaped = wrapped;
         end
         2'b01: begin
            // A crossed window is meaningless; fall back to one turn.
            shaped = win_ok ? rolled : wrapped;
         end
         2'b10: begin
            // The unwrapped sum hits a limit before it can roll over.
            shaped = sat_hi ? cfg.high_lim :
                     sat_lo ? cfg.low_lim : wrapped;
         end
         2'b11: begin
            shaped = w_hi ? cfg.high_lim :
                     w_lo ? cfg.low_lim : wrapped;
         end
      endcase
   end

   wire [12:0] inv_full = aap_pkg::FULL_TURN - {1'b0, shaped};
   wire [11:0] final_ang = cfg.polarity ? inv_full[11:0]
                                        : shaped;

   //==========================================================
   // Output register, updated once per averaged angle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid    <= 1'b0;
         out_angle    <= 12'h000;
         out_tristate <= 1'b0;
      end else begin
         out_valid <= avg_valid;
         if (avg_valid) begin
            out_angle    <= final_ang;
            out_tristate <= range_fault;
         end
      end
   end

   //==========================================================
   // Assertions.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Samples may come every cycle, so back-to-back means are legal.
   property p_once_per_avg;
      out_valid == $past(avg_valid);
   endproperty
   a_once_per_avg: assert property (p_once_per_avg)
      else $error("output not updated once per average");

   property p_avg_from_raw;
      avg_valid |-> $past(raw_valid);
   endproperty
   a_avg_from_raw: assert property (p_avg_from_raw)
      else $error("average without a sample");

   property p_sel_zero;
      cfg.sample_average_select == 3'h0 && raw_valid |=> avg_valid;
   endproperty
   a_sel_zero: assert property (p_sel_zero)
      else $error("single-sample mode lost a sample");

   property p_fault;
      avg_valid && cfg.narrow_en && !cfg.diag_mask &&
      (pre_ang > cfg.max_in) |=> out_tristate;
   endproperty
   a_fault: assert property (p_fault)
      else $error("over-limit angle not flagged");

   property p_mask;
      avg_valid && cfg.diag_mask |=> !out_tristate;
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked diagnostic forced tristate");

   property p_narrow_off;
      avg_valid && !cfg.narrow_en |=> !out_tristate;
   endproperty
   a_narrow_off: assert property (p_narrow_off)
      else $error("limit check active without narrow travel");

   property p_plain_wrap;
      avg_valid && !cfg.narrow_en && !cfg.polarity &&
      !cfg.limit_hold_en && !cfg.wrap_enable |=>
      out_angle == 12'($past(avg_ang) - $past(cfg.pre_shift)
                       + $past(cfg.post_scale_shift));
   endproperty
   a_plain_wrap: assert property (p_plain_wrap)
      else $error("plain path angle wrong");

   property p_hold;
      avg_valid && cfg.limit_hold_en && !cfg.polarity &&
      cfg.low_lim <= cfg.high_lim |=>
      out_angle >= $past(cfg.low_lim) && out_angle <= $past(cfg.high_lim);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held output outside limits");

   property p_polarity;
      avg_valid && cfg.polarity |=>
      12'(out_angle + $past(shaped)) == 12'h000;
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("inverted angle wrong");

   c_window_roll: cover property (avg_valid && !cfg.limit_hold_en &&
                                  cfg.wrap_enable && win_ok);
   c_fault_rise:  cover property ($rose(out_tristate));
   c_long_avg:    cover property (avg_valid &&
                                  cfg.sample_average_select == 3'h7);

endmodule // aap_top
`default_nettype wire

// ### testbench/aap_front_model.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// Front end and output driver stand-in: sends raw samples on request
// and counts every processed angle that the path hands over.
module aap_front_model (
   // Clock and reset.
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Raw sample stream towards the path.
   output logic              raw_valid,
   output logic [11:0]       raw_angle,
   output logic signed [7:0] die_temp,
   output logic signed [7:0] field_level,
   // Processed angle from the path.
   input  wire logic         out_valid,
   input  wire logic [11:0]  out_angle,
   input  wire logic         out_tristate
);
   int seen;  // Processed angles received since reset.

   // Quiet stream at time zero.
   initial begin
      raw_valid = 1'b0;
      raw_angle = 12'h000;
      die_temp = 8'sh00;
      field_level = 8'sh00;
   end

   // Sends n samples from a, stepping by st, gap idle cycles apart.
   // The level t is driven on both temperature and field inputs.
   // Between samples the angle bus shows a changing pattern, so that
   // the path cannot lean on a stale sample value.
   task automatic send(input logic [11:0] a, input logic [11:0] st,
                       input logic signed [7:0] t, input int n,
                       input int gap);
      logic [11:0] v;
      v = a;
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         raw_valid <= 1'b1;
         raw_angle <= v;
         die_temp <= t;
         field_level <= t;
         v = v + st;
         repeat (gap) begin
            @(posedge aclk);
            raw_valid <= 1'b0;
            raw_angle <= ~v;
         end
      end
      @(posedge aclk);
      raw_valid <= 1'b0;
      raw_angle <= ~v;
   endtask

   // Counts output pulses; one is due per completed group.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen <= 0;
      end else if (out_valid) begin
         seen <= seen + 1;
      end
   end
endmodule // aap_front_model
`default_nettype wire

// ### testbench/angle_postprocess_path_bench.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// Register-driven bench: configures the path, feeds samples, checks.
module angle_postprocess_path_bench;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        raw_valid, out_valid, out_tristate;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [11:0] raw_angle, out_angle;
   logic signed [7:0] die_temp, field_level;
   int          bad_count, comparisons, s0;
   logic [11:0] exp_a [4];  // Expected angle per output mode.

   aap_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .raw_valid,
      .raw_angle, .die_temp, .field_level, .out_valid, .out_angle,
      .out_tristate);
   aap_front_model fm (.aclk, .aresetn, .raw_valid, .raw_angle,
      .die_temp, .field_level, .out_valid, .out_angle, .out_tristate);

   // 100 ns clock.
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   //==========================================================
   // Checking and closing.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   //==========================================================
   // AXI4-Lite master; each channel is released at its own handshake.
   task automatic axw(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
      bit aw, w, b;
      int n;
      aw = 0; w = 0; b = 0; n = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w && b) && n < 50) begin
         @(posedge aclk);
         n++;
         if (awready) begin aw = 1; awvalid <= 1'b0; end
         if (wready) begin w = 1; wvalid <= 1'b0; end
         if (bvalid) begin b = 1; resp = bresp; bready <= 1'b0; end
      end
      if (n >= 50) bad_count++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] x;
      axw(a, v, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
      bit ar, rr;
      int n;
      ar = 0; rr = 0; n = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!(ar && rr) && n < 50) begin
         @(posedge aclk);
         n++;
         if (arready) begin ar = 1; arvalid <= 1'b0; end
         if (rvalid) begin
            rr = 1; v = rdata; resp = rresp; rready <= 1'b0;
         end
      end
      if (n >= 50) bad_count++;
   endtask

   // One sample at group size one; waits for its output and compares.
   task automatic meas(input logic [11:0] a, input logic signed [7:0] t,
                       input logic [11:0] ea, input logic et);
      int n;
      s0 = fm.seen;
      fm.send(a, 12'h000, t, 1, 0);
      n = 0;
      while (fm.seen == s0 && n < 20) begin
         @(posedge aclk);
         n++;
      end
      chk(fm.seen - s0, 1);
      chk(out_angle, ea);
      chk(out_tristate, et);
   endtask

   function automatic logic [31:0] lim(input logic h, input logic w,
                                       input logic [11:0] mx, mn);
      return {6'h00, h, w, mx, mn};
   endfunction

   // Hang guard; the whole run needs well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      report_and_stop();
   end

   //==========================================================
   // Test sequence.
   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'hf; bad_count = 0; comparisons = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(aap_pkg::ADDR_STAT, d, r); chk(d, 32'h0);
      axw(aap_pkg::ADDR_PRE, 32'hffffffff, r);
      chk(r, aap_pkg::RESP_OKAY);
      rd(aap_pkg::ADDR_PRE, d, r); chk(d, aap_pkg::MASK_PRE);
      chk(r, aap_pkg::RESP_OKAY);
      // Byte lane 2 alone clears only the top of the shift field.
      wstrb <= 4'h4;
      wr(aap_pkg::ADDR_PRE, 32'h0);
      wstrb <= 4'hf;
      rd(aap_pkg::ADDR_PRE, d, r); chk(d, 32'h0000f000);
      rd(8'h20, d, r); chk(r, aap_pkg::RESP_SLVERR);
      axw(aap_pkg::ADDR_STAT, 32'h1, r); chk(r, aap_pkg::RESP_SLVERR);
      // Pre shift wraps below zero.
      wr(aap_pkg::ADDR_PRE, 32'h00100000);
      meas(12'h050, 8'sh00, 12'hf50, 1'b0);
      wr(aap_pkg::ADDR_PRE, 32'h0);
      wr(aap_pkg::ADDR_MISC, 32'h00000100);
      meas(12'h100, 8'sh00, 12'hf00, 1'b0);
      wr(aap_pkg::ADDR_MISC, 32'h0);
      // Gain is ignored while narrow travel is off.
      wr(aap_pkg::ADDR_GAIN, 32'h00000300);
      meas(12'h100, 8'sh00, 12'h100, 1'b0);
      wr(aap_pkg::ADDR_LIM, lim(0, 0, 12'hfff, 12'h000));
      wr(aap_pkg::ADDR_GAIN, 32'h02000300);
      meas(12'h100, 8'sh00, 12'h400, 1'b0);
      wr(aap_pkg::ADDR_POST, 32'h00010000);
      meas(12'h100, 8'sh00, 12'h410, 1'b0);
      wr(aap_pkg::ADDR_POST, 32'h0);
      // Input beyond the max limit flags tristate in narrow travel unless masked.
      wr(aap_pkg::ADDR_LIM, lim(0, 0, 12'h200, 12'h080));
      meas(12'h300, 8'sh00, 12'hc00, 1'b1);
      wr(aap_pkg::ADDR_MISC, 32'h00000200);
      meas(12'h300, 8'sh00, 12'hc00, 1'b0);
      wr(aap_pkg::ADDR_MISC, 32'h0);
      wr(aap_pkg::ADDR_GAIN, 32'h00000300);
      meas(12'h300, 8'sh00, 12'h300, 1'b0);
      // Output modes, limits 0x100..0x800, unity gain.
      wr(aap_pkg::ADDR_CLAMP, 32'h00800100);
      exp_a = '{12'ha00, 12'h2ff, 12'h800, 12'h800};
      for (int m = 0; m < 4; m++) begin
         wr(aap_pkg::ADDR_LIM, lim(m[1], m[0], 12'hfff, 12'h000));
         meas(12'ha00, 8'sh00, exp_a[m], 1'b0);
      end
      // Below the window both clamping modes hold the low limit.
      for (int m = 2; m < 4; m++) begin
         wr(aap_pkg::ADDR_LIM, lim(m[1], m[0], 12'hfff, 12'h000));
         meas(12'h050, 8'sh00, 12'h100, 1'b0);
      end
      // A crossed window falls back to a plain turn.
      wr(aap_pkg::ADDR_CLAMP, 32'h00100800);
      wr(aap_pkg::ADDR_LIM, lim(0, 1, 12'hfff, 12'h000));
      meas(12'ha00, 8'sh00, 12'ha00, 1'b0);
      wr(aap_pkg::ADDR_CLAMP, 32'h00800100);
      // Gain of four pushes past one turn: only mode 10 saturates.
      wr(aap_pkg::ADDR_GAIN, 32'h02000300);
      exp_a = '{12'h400, 12'h400, 12'h800, 12'h400};
      for (int m = 0; m < 4; m++) begin
         wr(aap_pkg::ADDR_LIM, lim(m[1], m[0], 12'hfff, 12'h000));
         meas(12'h500, 8'sh00, exp_a[m], 1'b0);
      end
      wr(aap_pkg::ADDR_GAIN, 32'h0);
      wr(aap_pkg::ADDR_LIM, 32'h0);
      wr(aap_pkg::ADDR_CLAMP, 32'h0);
      // Temperature coefficient one at 64 units removes one code.
      wr(aap_pkg::ADDR_COEF, 32'h00000100);
      meas(12'h100, 8'sh40, 12'h0ff, 1'b0);
      // Field coefficient one at 64 units removes one code as well.
      wr(aap_pkg::ADDR_COEF, 32'h00000001);
      meas(12'h100, 8'sh40, 12'h0ff, 1'b0);
      wr(aap_pkg::ADDR_COEF, 32'h0);
      // Every group size gives exactly one output per group.
      for (int s = 0; s < 8; s++) begin
         wr(aap_pkg::ADDR_MISC, s);
         s0 = fm.seen;
         fm.send(12'h2a5, 12'h000, 8'sh00, 1 << s, 0);
         repeat (6) @(posedge aclk);
         chk(fm.seen - s0, 1);
         chk(out_angle, 12'h2a5);
      end
      // Slow, spaced samples of rising value average to their mean.
      wr(aap_pkg::ADDR_MISC, 32'h00000002);
      s0 = fm.seen;
      fm.send(12'h100, 12'h100, 8'sh00, 4, 3);
      repeat (6) @(posedge aclk);
      chk(fm.seen - s0, 1);
      chk(out_angle, 12'h280);
      report_and_stop();
   end
endmodule // angle_postprocess_path_bench
`default_nettype wire
